// ### design/rbs_pkg.sv
// Shared constants, types and register layout of the reset and brown-out sequencer
package rbs_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register bus
	localparam int          ADDR_W                   = 3;
	localparam logic [2:0]  BROWNOUT_CONTROL_OFFSET  = 3'h0;
	localparam logic [2:0]  SEQ_STATUS_OFFSET        = 3'h4;
	localparam int          SW_ENABLE_BIT            = 7;
	localparam int          READY_BIT                = 0;
	localparam logic        SW_ENABLE_RESET          = 1'b1;

	////////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLOCK_HZ               = 50_000_000;
	localparam int LF_OSC_HZ              = 31_000;
	// Low-frequency tick period in system clocks
	localparam int LF_DIVIDE              = CLOCK_HZ / LF_OSC_HZ;
	localparam int POWER_UP_DELAY_MS      = 64;
	localparam int POWER_UP_TICKS         = POWER_UP_DELAY_MS * LF_OSC_HZ / 1000;
	localparam int BROWNOUT_FILTER_TIME_NS = 1000;
	localparam int BROWNOUT_FILTER_CYCLES =
		(BROWNOUT_FILTER_TIME_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
	localparam int PIN_FILTER_TIME_NS     = 200;
	localparam int PIN_FILTER_CYCLES      =
		(PIN_FILTER_TIME_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
	localparam logic [2:0] SOFT_RESET_CYCLES = 3'h4;
	localparam int COUNT_W                = 16;

	////////////////////////////////////////////////////////////////////////////////
	// Modes, states and status layout
	typedef enum logic [1:0] {
		brownout_always_off   = 2'h0,
		brownout_software_mode = 2'h1,
		brownout_off_in_sleep = 2'h2,
		brownout_always_on    = 2'h3
	} rbs_mode_type;

	typedef enum logic [1:0] {
		st_hold  = 2'h0,
		st_timer = 2'h1,
		st_osc   = 2'h3,
		st_run   = 2'h2
	} rbs_state_type;

	typedef struct packed {
		logic          start_wait;
		logic          pin_hold;
		logic          brownout_active;
		logic          brownout_reset;
		rbs_state_type state;
		logic          timer_running;
		logic          device_reset;
	} rbs_status_type;

endpackage : rbs_pkg

// ### design/rbs_filter_if.sv
// Raw level and its filtered, persistence-checked version
interface rbs_filter_if;
	logic raw;
	logic held;
	modport filter (input raw, output held);
	modport user   (output raw, input held);
endinterface : rbs_filter_if

// ### design/rbs_filter.sv
// Persistence filter: output rises only after the input has stood high long enough
module rbs_filter #(
	parameter int CYCLES = 1
) (
	input  wire logic    clock,
	input  wire logic    reset,
	rbs_filter_if.filter line
);
	import rbs_pkg::*;

	logic [COUNT_W-1:0] count;

	// Count consecutive high cycles; any low sample restarts, so short dips vanish
	always_ff @(posedge clock) begin
		if (reset || !line.raw) begin
			count     <= '0;
			line.held <= 1'b0;
		end else if (count != COUNT_W'(CYCLES)) begin
			count <= count + 1'b1;
		end else begin
			line.held <= 1'b1;
		end
	end

endmodule : rbs_filter

// ### design/rbs_divider.sv
// Divider giving a one-cycle tick at the low-frequency oscillator rate
module rbs_divider (
	input  wire logic             clock,
	input  wire logic             reset,
	input  wire logic [15:0]      divide,
	output logic                  tick
);
	import rbs_pkg::*;

	logic [15:0] count;

	// Free running; the tick is the enable for all slow counting
	always_ff @(posedge clock) begin
		if (reset) begin
			count <= 16'h0;
			tick  <= 1'b0;
		end else if (count >= divide - 16'h1) begin
			count <= 16'h0;
			tick  <= 1'b1;
		end else begin
			count <= count + 16'h1;
			tick  <= 1'b0;
		end
	end

endmodule : rbs_divider

// ### design/rbs_sequencer.sv
// Reset merging, power-up delay and brown-out control with its register slave
//
// Chosen here: register access over Avalon-MM and the register offsets.
module rbs_sequencer #(
	parameter int POWER_UP_TICKS_P = rbs_pkg::POWER_UP_TICKS,
	parameter int LF_DIVIDE_P      = rbs_pkg::LF_DIVIDE
) (
	input  wire logic                      clock,
	input  wire logic                      reset,
	// Avalon-MM slave
	input  wire logic [rbs_pkg::ADDR_W-1:0] address,
	input  wire logic                      read,
	input  wire logic                      write,
	input  wire logic [31:0]               writedata,
	input  wire logic [3:0]                byteenable,
	output logic      [31:0]               readdata,
	output logic                           waitrequest,
	// Analog monitors and pin, asynchronous
	input  wire logic                      power_on_low,
	input  wire logic                      brownout_below,
	input  wire logic                      brownout_circuit_ready,
	input  wire logic                      external_reset_pin_n,
	input  wire logic                      osc_start_done,
	// Configuration word bits, asynchronous
	input  wire logic [1:0]                brownout_mode_select,
	input  wire logic                      power_timer_enable_n,
	input  wire logic                      external_reset_enable,
	// Core events on this clock
	input  wire logic                      sleep_mode,
	input  wire logic                      watchdog_timeout,
	input  wire logic                      reset_instruction,
	input  wire logic                      stack_overflow,
	input  wire logic                      stack_underflow,
	input  wire logic                      program_mode_exit,
	// Outputs
	output logic                           device_reset,
	output logic                           brownout_enable,
	output logic                           wake_permit
);
	import rbs_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Synchronisers for everything arriving from outside the clock domain

	localparam int SYNC_W = 9;

	logic [SYNC_W-1:0] sync_meta;
	logic [SYNC_W-1:0] sync_out;
	logic              por_s;
	logic              below_s;
	logic              ready_s;
	logic              pin_n_s;
	logic              osc_done_s;
	rbs_mode_type      mode;
	logic              timer_enable_n_s;
	logic              pin_enable_s;

	// Two stages; only the second stage is read anywhere
	always_ff @(posedge clock) begin
		if (reset) begin
			sync_meta <= 9'h0;
			sync_out  <= 9'h0;
		end else begin
			sync_meta <= {power_on_low, brownout_below, brownout_circuit_ready,
				external_reset_pin_n, osc_start_done, brownout_mode_select,
				power_timer_enable_n, external_reset_enable};
			sync_out  <= sync_meta;
		end
	end

	assign por_s            = sync_out[8];
	assign below_s          = sync_out[7];
	assign ready_s          = sync_out[6];
	assign pin_n_s          = sync_out[5];
	assign osc_done_s       = sync_out[4];
	assign mode             = rbs_mode_type'(sync_out[3:2]);
	assign timer_enable_n_s = sync_out[1];
	assign pin_enable_s     = sync_out[0];

	////////////////////////////////////////////////////////////////////////////////
	// Brown-out mode control

	logic sw_enable;
	logic brownout_active;
	logic brownout_protect;
	logic brownout_hold;
	logic start_wait;
	logic pin_hold;

	// Mode decode of the protection enable, which also powers the analog circuit
	always_comb begin
		case (mode)
			brownout_always_on:     brownout_active = 1'b1;
			brownout_off_in_sleep:  brownout_active = !sleep_mode;
			brownout_software_mode: brownout_active = sw_enable;
			default:                brownout_active = 1'b0;
		endcase
	end

	assign brownout_enable  = brownout_active;
	// Protection only bites once the circuit says it is ready
	assign brownout_protect = brownout_active && ready_s;

	// Only hardware-timed modes make start-up wait for the circuit and supply
	assign start_wait = (mode == brownout_always_on || mode == brownout_off_in_sleep)
		&& (!ready_s || below_s);

	// Wake-up waits for the circuit only in the off-in-sleep mode
	always_ff @(posedge clock) begin
		if (reset) begin
			wake_permit <= 1'b0;
		end else begin
			wake_permit <= (mode != brownout_off_in_sleep) || ready_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Filters for the brown-out comparator and the reset pin

	rbs_filter_if brownout_line ();
	rbs_filter_if pin_line ();

	assign brownout_line.raw = below_s && brownout_protect;
	assign pin_line.raw = pin_enable_s && !pin_n_s;

	rbs_filter #(
		.CYCLES (BROWNOUT_FILTER_CYCLES)
	) u_brownout_filter (
		.clock (clock),
		.reset (reset),
		.line  (brownout_line)
	);

	rbs_filter #(
		.CYCLES (PIN_FILTER_CYCLES)
	) u_pin_filter (
		.clock (clock),
		.reset (reset),
		.line  (pin_line)
	);

	assign brownout_hold = brownout_line.held;
	assign pin_hold      = pin_line.held;

	////////////////////////////////////////////////////////////////////////////////
	// Low-frequency tick and power-up delay

	logic                tick;
	logic [COUNT_W-1:0]  timer_count;
	rbs_state_type       state;
	rbs_state_type       next_state;

	rbs_divider u_divider (
		.clock  (clock),
		.reset  (reset),
		.divide (COUNT_W'(LF_DIVIDE_P)),
		.tick   (tick)
	);

	// Counts ticks only in the timer state; cleared on every re-entry
	always_ff @(posedge clock) begin
		if (reset || state != st_timer) begin
			timer_count <= '0;
		end else if (tick) begin
			timer_count <= timer_count + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Start-up sequence

	// Power-type holds pull back to the start from any state
	always_comb begin
		next_state = state;
		if (por_s || brownout_hold || program_mode_exit) begin
			next_state = st_hold;
		end else begin
			case (state)
				st_hold: begin
					if (!start_wait) begin
						next_state = timer_enable_n_s ? st_osc : st_timer;
					end
				end
				st_timer: begin
					if (tick && timer_count == COUNT_W'(POWER_UP_TICKS_P - 1)) begin
						next_state = st_osc;
					end
				end
				st_osc: begin
					if (osc_done_s) begin
						next_state = st_run;
					end
				end
				default: next_state = st_run;
			endcase
		end
	end

	// The pin is not part of the sequence, so timers expire under a held pin
	always_ff @(posedge clock) begin
		if (reset) begin
			state <= st_hold;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Core reset sources and the merged output

	logic       soft_pulse;
	logic [2:0] soft_count;

	assign soft_pulse = watchdog_timeout || reset_instruction
		|| stack_overflow || stack_underflow;

	// Short stretch so a one-cycle request still gives a clean reset pulse
	always_ff @(posedge clock) begin
		if (reset) begin
			soft_count <= 3'h0;
		end else if (soft_pulse) begin
			soft_count <= SOFT_RESET_CYCLES;
		end else if (soft_count != 3'h0) begin
			soft_count <= soft_count - 3'h1;
		end
	end

	// One registered output; asserted whenever any hold is present
	always_ff @(posedge clock) begin
		if (reset) begin
			device_reset <= 1'b1;
		end else begin
			device_reset <= (state != st_run) || por_s || brownout_hold || pin_hold
				|| program_mode_exit || soft_pulse || soft_count != 3'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave: one wait state on every access

	logic           served;
	logic           request;
	rbs_status_type status;

	assign request     = read || write;
	assign waitrequest = request && !served;

	assign status = '{
		start_wait:      start_wait,
		pin_hold:        pin_hold,
		brownout_active: brownout_active,
		brownout_reset:  brownout_hold,
		state:           state,
		timer_running:   state == st_timer,
		device_reset:    device_reset
	};

	// Served is high for the one cycle in which the master sees waitrequest low
	always_ff @(posedge clock) begin
		if (reset) begin
			served <= 1'b0;
		end else begin
			served <= request && !served;
		end
	end

	// Read data is loaded during the wait state so it stands at completion
	always_ff @(posedge clock) begin
		if (reset) begin
			readdata <= 32'h0;
		end else if (read && !served) begin
			if (address == BROWNOUT_CONTROL_OFFSET) begin
				readdata                <= 32'h0;
				readdata[SW_ENABLE_BIT] <= sw_enable;
				readdata[READY_BIT]     <= ready_s;
			end else if (address == SEQ_STATUS_OFFSET) begin
				readdata <= {24'h0, status};
			end else begin
				readdata <= 32'h0;
			end
		end
	end

	// Writable in every mode; the mode decode decides if it matters
	always_ff @(posedge clock) begin
		if (reset) begin
			sw_enable <= SW_ENABLE_RESET;
		end else if (write && served && byteenable[0]
			&& address == BROWNOUT_CONTROL_OFFSET) begin
			sw_enable <= writedata[SW_ENABLE_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions and covers

	// Cycles in the delay state; checks the delay length apart from the tick counter
	logic [31:0] timer_cycles;
	always_ff @(posedge clock) begin
		timer_cycles <= (reset || state != st_timer) ? 32'h0 : timer_cycles + 32'h1;
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	a_por_holds_reset: assert property (
		por_s |=> device_reset && state == st_hold)
		else $error("Reset not held under power-on condition");
	a_timer_holds_reset: assert property (
		state == st_timer |=> device_reset)
		else $error("Reset released while delay timer counts");
	a_timer_after_release: assert property (
		state == st_hold ##1 state == st_timer |-> !$past(por_s) && !$past(brownout_hold))
		else $error("Delay timer started before holds released");
	a_timer_disabled: assert property (
		(state == st_hold && timer_enable_n_s) |=> state != st_timer)
		else $error("Delay timer ran while disabled");
	a_timer_length: assert property (
		(state == st_timer && next_state == st_osc) |->
			timer_cycles >= 32'((POWER_UP_TICKS_P - 1) * LF_DIVIDE_P)
			&& timer_cycles < 32'(POWER_UP_TICKS_P * LF_DIVIDE_P))
		else $error("Delay timer ended at wrong count");
	a_mode_decode: assert property (
		(mode == brownout_always_off |-> !brownout_enable)
		and (mode == brownout_always_on |-> brownout_enable))
		else $error("Brown-out enable wrong for mode");
	a_sleep_modes: assert property (
		(mode == brownout_off_in_sleep && sleep_mode) |-> !brownout_enable)
		else $error("Protection left on in sleep");
	a_soft_mode: assert property (
		mode == brownout_software_mode |-> brownout_enable == sw_enable)
		else $error("Software enable not followed");
	a_core_source: assert property (
		soft_pulse |=> device_reset [*4])
		else $error("Core reset request not stretched");
	a_reserved_zero: assert property (
		(read && served && address == BROWNOUT_CONTROL_OFFSET) |-> readdata[6:1] == 6'h0)
		else $error("Reserved control bits not zero");
	a_pin_release: assert property (
		(state == st_run && pin_hold ##1 !pin_hold && !por_s && !brownout_hold
			&& !soft_pulse && soft_count == 3'h0 && state == st_run
			&& !program_mode_exit) |=> !device_reset)
		else $error("Release after pin not immediate");
	c_timer_done: cover property (state == st_timer ##1 state == st_osc);
	c_brownout_trip: cover property (!brownout_hold ##1 brownout_hold);
	c_sw_write: cover property (write && served && address == BROWNOUT_CONTROL_OFFSET);
endmodule : rbs_sequencer

// ### sim/rbs_analog_model.sv
// Behavioural model of the supply monitors, oscillator start-up timer and reset pin
module rbs_analog_model #(
	parameter int READY_DELAY = 40,
	parameter int OSC_DELAY   = 2
) (
	input  wire logic       clock,
	input  wire logic [1:0] supply_level,
	input  wire logic       pin_low,
	input  wire logic       brownout_enable,
	output logic            power_on_low,
	output logic            brownout_below,
	output logic            brownout_circuit_ready,
	output logic            external_reset_pin_n,
	output logic            osc_start_done
);
	timeunit 1ns;
	timeprecision 1ns;
	int   ready_count = 0;
	int   osc_count   = 0;
	logic toggle      = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// Circuit settles only after staying powered and enabled; oscillator after power
	always @(posedge clock) begin
		toggle <= !toggle;
		if (!brownout_enable || supply_level == 2'h0) begin
			ready_count <= 0;
		end else if (ready_count < READY_DELAY) begin
			ready_count <= ready_count + 1;
		end
		if (supply_level == 2'h0) begin
			osc_count <= 0;
		end else if (osc_count < OSC_DELAY) begin
			osc_count <= osc_count + 1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// An unpowered comparator gives no trustworthy level, so it wanders every cycle
	assign brownout_circuit_ready = ready_count >= READY_DELAY;
	assign brownout_below         = brownout_circuit_ready ? supply_level != 2'h2 : toggle;
	assign power_on_low           = supply_level == 2'h0;
	assign osc_start_done         = osc_count >= OSC_DELAY;
	// Weak pull-up keeps the pin high unless pulled
	assign external_reset_pin_n   = !pin_low;
endmodule : rbs_analog_model

// ### sim/reset_brownout_sequencer_test.sv
// Self-checking bench of the reset and brown-out sequencer
module reset_brownout_sequencer_test import rbs_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TICKS = 3;
	localparam int DIV   = 4;
	logic        clock = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0;
	logic [2:0]  address = 3'h0;
	logic [31:0] writedata = 32'h0, readdata, rd;
	logic [3:0]  byteenable = 4'h0;
	logic        waitrequest, device_reset, brownout_enable, wake_permit;
	logic        pol, bbl, rdy, pin_n, osc;
	logic [1:0]  supply_level = 2'h0, mode = 2'h0;
	logic        pin_low = 1'b0, timer_n = 1'b0, sleep = 1'b0, pin_en = 1'b1;
	logic [4:0]  core_events = 5'h0;
	int          mismatches = 0, checks_done = 0, cycles = 0, n, bus_edges;

	rbs_sequencer #(.POWER_UP_TICKS_P(TICKS), .LF_DIVIDE_P(DIV)) i_rbs_sequencer (
		.clock(clock), .reset(reset), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .power_on_low(pol), .brownout_below(bbl),
		.brownout_circuit_ready(rdy), .external_reset_pin_n(pin_n), .osc_start_done(osc),
		.brownout_mode_select(mode), .power_timer_enable_n(timer_n),
		.external_reset_enable(pin_en), .sleep_mode(sleep),
		.watchdog_timeout(core_events[0]), .reset_instruction(core_events[1]),
		.stack_overflow(core_events[2]), .stack_underflow(core_events[3]),
		.program_mode_exit(core_events[4]), .device_reset(device_reset),
		.brownout_enable(brownout_enable), .wake_permit(wake_permit));
	rbs_analog_model i_rbs_analog_model (
		.clock(clock), .supply_level(supply_level), .pin_low(pin_low),
		.brownout_enable(brownout_enable), .power_on_low(pol), .brownout_below(bbl),
		.brownout_circuit_ready(rdy), .external_reset_pin_n(pin_n), .osc_start_done(osc));

	////////////////////////////////////////////////////////////////////////////////
	// Clock and a hang guard well above the expected run length
	always #10 clock = !clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic step(input int k);
		repeat (k) @(posedge clock);
	endtask : step

	// One Avalon access; request held until waitrequest is sampled low, only the hang guard
	// ends a wait that never finishes; bus_edges keeps the edges the access took
	task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d,
			input logic [3:0] be, output logic [31:0] q);
		address <= a;
		writedata <= d;
		byteenable <= be;
		read <= !wr;
		write <= wr;
		bus_edges = 0;
		do begin
			@(posedge clock);
			bus_edges++;
		end while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clock);
	endtask : bus

	// Cycles until the merged reset lets go
	task automatic release_time(output int k);
		k = 0;
		while (device_reset !== 1'b0 && k < 500) begin
			@(posedge clock);
			k++;
		end
		// A release that never comes must not pass as a long one
		check("release in time", 32'(k < 500), 32'h1);
	endtask : release_time

	task automatic power_cycle(output int k);
		supply_level <= 2'h0;
		step(10);
		supply_level <= 2'h2;
		release_time(k);
	endtask : power_cycle

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic test_registers();
		bus(1'b0, 3'h0, 32'h0, 4'h0, rd);
		check("control at reset", rd, 32'h80);
		check("wait states", bus_edges, 32'h2);
		bus(1'b1, 3'h0, 32'h0, 4'h0, rd);
		bus(1'b0, 3'h0, 32'h0, 4'h0, rd);
		check("masked write", rd, 32'h80);
		bus(1'b1, 3'h0, 32'h7e, 4'hf, rd);
		bus(1'b0, 3'h0, 32'h0, 4'h0, rd);
		check("control cleared", rd, 32'h0);
		bus(1'b1, 3'h2, 32'hff, 4'hf, rd);
		bus(1'b0, 3'h2, 32'h0, 4'h0, rd);
		check("unmapped read", rd, 32'h0);
		bus(1'b1, 3'h0, 32'h80, 4'h1, rd);
		bus(1'b0, 3'h4, 32'h0, 4'h0, rd);
		check("status in hold", 32'(rd[3:0]), 32'h1);
	endtask : test_registers

	task automatic test_power_up();
		power_cycle(n);
		check("stretched start", 32'(n >= TICKS * DIV), 32'h1);
		timer_n <= 1'b1;
		power_cycle(n);
		check("unstretched start", 32'(n < TICKS * DIV), 32'h1);
		timer_n <= 1'b0;
		supply_level <= 2'h0;
		pin_low <= 1'b1;
		step(10);
		supply_level <= 2'h2;
		step(60);
		check("pin holds", 32'(device_reset), 32'h1);
		bus(1'b0, 3'h4, 32'h0, 4'h0, rd);
		check("timers done under pin", 32'(rd[3:2]), 32'h2);
		pin_low <= 1'b0;
		release_time(n);
		check("prompt pin release", 32'(n <= 20), 32'h1);
	endtask : test_power_up

	task automatic test_core_sources();
		for (int i = 0; i < 5; i++) begin
			core_events <= 5'h1 << i;
			step(1);
			core_events <= 5'h0;
			step(2);
			check("core source", 32'(device_reset), 32'h1);
			release_time(n);
		end
		pin_low <= 1'b1;
		step(30);
		check("pin reset", 32'(device_reset), 32'h1);
		pin_low <= 1'b0;
		release_time(n);
		// With the pin function switched off a low pin must not reset
		pin_en <= 1'b0;
		pin_low <= 1'b1;
		step(30);
		check("pin disabled", 32'(device_reset), 32'h0);
		pin_low <= 1'b0;
		pin_en <= 1'b1;
		step(4);
	endtask : test_core_sources

	task automatic test_brownout_modes();
		mode <= 2'h3;
		power_cycle(n);
		check("start waits ready", 32'(n >= 40), 32'h1);
		supply_level <= 2'h1;
		step(20);
		supply_level <= 2'h2;
		step(10);
		check("short dip", 32'(device_reset), 32'h0);
		supply_level <= 2'h1;
		step(80);
		check("long dip", 32'(device_reset), 32'h1);
		supply_level <= 2'h2;
		release_time(n);
		check("brown-out stretch", 32'(n >= TICKS * DIV), 32'h1);
		sleep <= 1'b1;
		step(3);
		check("on in sleep", 32'(brownout_enable), 32'h1);
		check("wake free", 32'(wake_permit), 32'h1);
		sleep <= 1'b0;
		mode <= 2'h2;
		step(4);
		sleep <= 1'b1;
		step(4);
		check("off in sleep", 32'(brownout_enable), 32'h0);
		supply_level <= 2'h1;
		step(80);
		check("no trip asleep", 32'(device_reset), 32'h0);
		supply_level <= 2'h2;
		sleep <= 1'b0;
		step(5);
		check("wake waits", 32'(wake_permit), 32'h0);
		step(60);
		check("wake after ready", 32'(wake_permit), 32'h1);
	endtask : test_brownout_modes

	task automatic test_software_mode();
		mode <= 2'h1;
		timer_n <= 1'b1;
		power_cycle(n);
		check("start ignores ready", 32'(n < TICKS * DIV), 32'h1);
		timer_n <= 1'b0;
		bus(1'b1, 3'h0, 32'h0, 4'h1, rd);
		step(3);
		check("software off", 32'(brownout_enable), 32'h0);
		bus(1'b0, 3'h0, 32'h0, 4'h0, rd);
		check("inactive status", rd, 32'h0);
		supply_level <= 2'h1;
		step(80);
		check("no trip disabled", 32'(device_reset), 32'h0);
		supply_level <= 2'h2;
		bus(1'b1, 3'h0, 32'h80, 4'h1, rd);
		step(50);
		bus(1'b0, 3'h0, 32'h0, 4'h0, rd);
		check("ready status", rd, 32'h81);
		sleep <= 1'b1;
		step(3);
		check("sleep unchanged", 32'(brownout_enable), 32'h1);
		sleep <= 1'b0;
		supply_level <= 2'h1;
		step(80);
		check("software trip", 32'(device_reset), 32'h1);
		supply_level <= 2'h2;
		release_time(n);
	endtask : test_software_mode

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		step(2);
		reset <= 1'b0;
		step(1);
		test_registers();
		test_power_up();
		test_core_sources();
		test_brownout_modes();
		test_software_mode();
		tally_and_finish();
	end
endmodule : reset_brownout_sequencer_test
